/* rtl/wfm_seq_pkg.sv */
// Shared widths, constants and carrier structs for the burst/marker sequencer.
// Assumes one update clock drives the whole sequencer.
package wfm_seq_pkg;
	localparam int ADDR_W = 14;
	localparam int LEN_W = 16;
	localparam int LOOP_W = 8;
	localparam int DUR_W = 24;
	localparam int FCW_W = 32;
	localparam int ATT_N = 4;
	localparam int MARK_LEN = 8;
	localparam int MARK_ALIGN = 3;
	localparam logic [MARK_ALIGN-1:0] MARK_ALIGN_ZERO = 3'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN = 2'b10
	} seq_state_e;

	// One staging-list entry; a single marker field per stage
	typedef struct packed {
		logic [ADDR_W-1:0] base;
		logic [LEN_W-1:0] len;
		logic [LOOP_W-1:0] loops;
		logic mark_en;
		logic [LEN_W-1:0] mark_off;
		logic [FCW_W-1:0] freq;
		logic [DUR_W-1:0] dur;
	} stage_s;

	typedef struct packed {
		logic out_en;
		logic [ATT_N-1:0] att_sel;
		logic filt_bypass;
		logic imp_75;
		logic preoff_en;
	} out_ctrl_s;
endpackage : wfm_seq_pkg

/* rtl/trig_sync.sv */
// Trigger front end: synchronises the external pin and merges software triggers.
// Assumes sw_trig is a one-cycle pulse from logic on clk.
`timescale 1ns/1ps
`default_nettype none
module trig_sync (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ext_trig,
	input wire logic ext_sel,
	input wire logic sw_trig,
	output logic trig
);
	import wfm_seq_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic trig;
	} ts_s;

	ts_s s_ff, nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.s1 = ext_trig;
		nxt_s.s2 = s_ff.s1;
		nxt_s.s3 = s_ff.s2;
		// Rising edge only; s1 feeds nothing but s2
		nxt_s.trig = sw_trig | (ext_sel & s_ff.s2 & ~s_ff.s3);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign trig = s_ff.trig;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_edge_once: assert property (ext_sel & ~sw_trig & s_ff.trig |=> ~s_ff.trig | $past(sw_trig))
		else $error("external trigger gave more than one pulse");
endmodule : trig_sync
`default_nettype wire

/* rtl/marker_pulse.sv */
// Marker pulse stretcher: fixed-length pulse per start request.
// Assumes start comes from logic on clk; clr dominates start.
`timescale 1ns/1ps
`default_nettype none
module marker_pulse (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic clr,
	output logic marker
);
	import wfm_seq_pkg::*;

	localparam logic [3:0] LAST = 4'(MARK_LEN - 1);

	typedef struct packed {
		logic on;
		logic [3:0] cnt;
	} mp_s;

	mp_s s_ff, nxt_s;

	always_comb begin
		nxt_s = s_ff;
		if (clr) begin
			nxt_s = '0;
		end else if (start) begin
			nxt_s.on = 1'b1;
			nxt_s.cnt = LAST;
		end else if (s_ff.cnt != 4'h0) begin
			nxt_s.cnt = s_ff.cnt - 4'h1;
		end else begin
			nxt_s.on = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign marker = s_ff.on;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// A clear may cut the pulse short; only an unforced drop is an error
	a_pulse_width: assert property (s_ff.on & ~clr & (s_ff.cnt != 4'h0) |=> s_ff.on)
		else $error("marker shorter than eight clocks");
	a_pulse_load: assert property ($rose(s_ff.on) |-> s_ff.cnt == LAST)
		else $error("marker pulse loaded with wrong length");
	a_pulse_ends: assert property (s_ff.on & ~start & ~clr ##1 ~start & ~clr [*8] |-> ~s_ff.on)
		else $error("marker longer than eight clocks");
	c_marker_seen: cover property ($rose(s_ff.on));
endmodule : marker_pulse
`default_nettype wire

/* rtl/wfm_seq.sv */
// Burst sequencer with stage table, DDS accumulator, marker and output path controls.
// Assumes cfg writes and sw_trig come from logic on clk; ext_trig is an async pin.
`timescale 1ns/1ps
`default_nettype none
module wfm_seq #(
	parameter int STAGE_AW = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic run,
	input wire logic dds_mode,
	input wire logic burst_mode,
	input wire logic ext_sel,
	input wire logic ext_trig,
	input wire logic sw_trig,
	input wire logic [STAGE_AW-1:0] last_stage,
	input wire logic cfg_we,
	input wire logic [STAGE_AW-1:0] cfg_idx,
	input wire wfm_seq_pkg::stage_s cfg_stage,
	input wire wfm_seq_pkg::out_ctrl_s ctl_in,
	output logic [wfm_seq_pkg::ADDR_W-1:0] sample_addr,
	output logic [wfm_seq_pkg::FCW_W-1:0] phase_acc,
	output logic [STAGE_AW-1:0] stage_idx,
	output logic running,
	output logic marker,
	output wfm_seq_pkg::out_ctrl_s ctl_out,
	output logic relay_on
);
	import wfm_seq_pkg::*;

	if (STAGE_AW < 1 || STAGE_AW > 9) begin : g_chk
		$error("STAGE_AW out of range");
	end

	localparam int DEPTH = 1 << STAGE_AW;

	typedef struct packed {
		seq_state_e st;
		logic [STAGE_AW-1:0] idx;
		logic [LEN_W-1:0] pos;
		logic [LOOP_W-1:0] loop;
		logic [DUR_W-1:0] dur;
		logic [FCW_W-1:0] phase;
		logic pend;
		logic [ADDR_W-1:0] addr;
		out_ctrl_s ctl;
		logic relay;
		logic active;
	} seq_s;

	seq_s s_ff, nxt_s;
	stage_s stage_mem [DEPTH];
	stage_s stg;
	logic trig;
	logic end_pass;
	logic adv;
	logic mark_start;
	logic mark_clr;

	function automatic logic [LEN_W-1:0] align_down(input logic [LEN_W-1:0] off);
		return {off[LEN_W-1:MARK_ALIGN], MARK_ALIGN_ZERO};
	endfunction : align_down

	function automatic logic [STAGE_AW-1:0] next_idx(input logic [STAGE_AW-1:0] i,
			input logic [STAGE_AW-1:0] last);
		return (i >= last) ? '0 : i + 1'b1;
	endfunction : next_idx

	// Table has no reset; software loads it before starting
	always_ff @(posedge clk) begin
		if (cfg_we) begin
			stage_mem[cfg_idx] <= cfg_stage;
		end
	end

	assign stg = stage_mem[s_ff.idx];

	trig_sync u_trig (
		.clk(clk),
		.arst_n(arst_n),
		.ext_trig(ext_trig),
		.ext_sel(ext_sel),
		.sw_trig(sw_trig),
		.trig(trig)
	);

	always_comb begin
		nxt_s = s_ff;
		end_pass = (LEN_W'(s_ff.pos + 1'b1) >= stg.len) | (s_ff.pos == '1);
		adv = 1'b0;
		// Path settings track software every clock, sequencer untouched
		nxt_s.ctl = ctl_in;
		nxt_s.relay = ctl_in.out_en;
		nxt_s.addr = ADDR_W'(stg.base + s_ff.pos[ADDR_W-1:0]);
		case (s_ff.st)
			ST_IDLE: begin
				nxt_s.idx = '0;
				nxt_s.pos = '0;
				nxt_s.loop = '0;
				nxt_s.dur = '0;
				nxt_s.pend = 1'b0;
				nxt_s.phase = '0;
				if (run) begin
					nxt_s.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (!run) begin
					nxt_s.st = ST_IDLE;
				end else if (trig) begin
					nxt_s.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!run) begin
					nxt_s.st = ST_IDLE;
				end else if (dds_mode) begin
					// Accumulator never reloaded on a stage change
					nxt_s.phase = s_ff.phase + stg.freq;
					if (burst_mode) begin
						adv = trig;
					end else begin
						nxt_s.dur = s_ff.dur + 1'b1;
						adv = (s_ff.dur + 1'b1) >= stg.dur;
					end
				end else begin
					nxt_s.pos = end_pass ? '0 : s_ff.pos + 1'b1;
					if (burst_mode) begin
						// Trigger is held until the pass boundary
						nxt_s.pend = (s_ff.pend | trig) & ~end_pass;
						adv = end_pass & (s_ff.pend | trig);
					end else if (end_pass) begin
						nxt_s.loop = s_ff.loop + 1'b1;
						adv = (s_ff.loop + 1'b1) >= stg.loops;
					end
				end
				if (adv) begin
					nxt_s.idx = next_idx(s_ff.idx, last_stage);
					nxt_s.loop = '0;
					nxt_s.dur = '0;
					nxt_s.pos = '0;
				end
			end
			default: begin
				nxt_s.st = ST_IDLE;
			end
		endcase
		// Registered so the status pin comes straight from a flop
		nxt_s.active = (nxt_s.st == ST_RUN);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Arb passes only; out-of-range offset never matches
	assign mark_start = (s_ff.st == ST_RUN) & run & ~dds_mode & stg.mark_en &
		(stg.mark_off < stg.len) & (s_ff.pos == align_down(stg.mark_off));
	assign mark_clr = (s_ff.st != ST_RUN) | ~run;

	marker_pulse u_mark (
		.clk(clk),
		.arst_n(arst_n),
		.start(mark_start),
		.clr(mark_clr),
		.marker(marker)
	);

	assign sample_addr = s_ff.addr;
	assign phase_acc = s_ff.phase;
	assign stage_idx = s_ff.idx;
	assign running = s_ff.active;
	assign ctl_out = s_ff.ctl;
	assign relay_on = s_ff.relay;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	logic in_run;
	assign in_run = (s_ff.st == ST_RUN) & run;

	a_hold_stage: assert property (in_run & ~dds_mode & burst_mode & ~s_ff.pend & ~trig |=> stage_idx == $past(stage_idx))
		else $error("burst stage moved without a trigger");
	a_finish_pass: assert property (in_run & ~dds_mode & burst_mode & ~end_pass |=> stage_idx == $past(stage_idx) ##0 s_ff.pos == $past(s_ff.pos) + 1'b1)
		else $error("stage changed before buffer pass ended");
	a_wrap_first: assert property (in_run & adv & (s_ff.idx >= last_stage) |=> stage_idx == '0)
		else $error("sequence did not wrap to first stage");
	a_phase_cont: assert property (in_run & dds_mode & adv |=> phase_acc == $past(phase_acc) + $past(stg.freq))
		else $error("phase jumped at stage change");
	a_dds_pace: assert property (in_run & dds_mode & burst_mode & ~trig |=> stage_idx == $past(stage_idx))
		else $error("DDS burst advanced without trigger");
	// Eight clocks in lets a pulse from the previous stage run out first
	a_mark_range: assert property ((in_run & ~dds_mode & (stg.mark_off >= stg.len)) [*8] |=> ~marker)
		else $error("marker shown for out-of-range offset");
	a_mark_align: assert property (mark_start |-> s_ff.pos[MARK_ALIGN-1:0] == MARK_ALIGN_ZERO ##1 marker)
		else $error("marker start not aligned or not shown");
	a_mark_stop: assert property (~running |=> ~marker)
		else $error("marker active while stopped");
	a_relay_gnd: assert property (~ctl_in.out_en |=> ~relay_on ##0 ctl_out.out_en == 1'b0)
		else $error("output not grounded when disabled");
	a_seq_runs: assert property (in_run & ~dds_mode & ~end_pass & ~ctl_in.out_en |=> s_ff.pos == $past(s_ff.pos) + 1'b1)
		else $error("sequencing stalled while output disabled");
	a_path_follow: assert property (1'b1 |=> ctl_out == $past(ctl_in))
		else $error("output path settings not applied next clock");

	c_burst_adv: cover property (in_run & burst_mode & ~dds_mode & adv);
	c_wrap: cover property (in_run & adv & (s_ff.idx >= last_stage) & (last_stage != '0));
	c_dds_hop: cover property (in_run & dds_mode & adv);
endmodule : wfm_seq
`default_nettype wire

/* bench/trig_src.sv */
// Model of the external trigger source that drives the trigger pin.
// Assumes the bench calls fire just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module trig_src (
	output logic pin
);
	initial pin = 1'b0;
	// Clean rising edge, held eight clocks so the synchroniser sees it
	task automatic fire();
		pin = 1'b1;
		#40;
		pin = 1'b0;
		#40;
	endtask : fire
endmodule : trig_src
`default_nettype wire

/* bench/wfm_seq_tb.sv */
// Self-checking bench for the burst sequencer, marker and output path.
// Assumes the trig_src model on the trigger pin; software side is this bench.
`timescale 1ns/1ps
`default_nettype none
module wfm_seq_tb;
	import wfm_seq_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic run = 1'b0;
	logic dds_mode = 1'b0;
	logic burst_mode = 1'b1;
	logic sw_trig = 1'b0;
	logic cfg_we = 1'b0;
	logic ext_trig;
	logic [3:0] cfg_idx = 4'h0;
	stage_s cfg_stage = '0;
	out_ctrl_s ctl_in = 8'h80;
	logic [ADDR_W-1:0] sample_addr;
	logic [FCW_W-1:0] phase_acc;
	logic [3:0] stage_idx;
	logic running;
	logic marker;
	out_ctrl_s ctl_out;
	logic relay_on;
	int miscompares = 0;
	int n_tests = 0;
	int nrise = 0;
	int mlen = 0;
	int cnt = 0;
	int lastr = 0;
	logic [FCW_W-1:0] p;
	trig_src src (.pin(ext_trig));
	wfm_seq #(.STAGE_AW(4)) DUT (.clk(clk), .arst_n(arst_n), .run(run), .dds_mode(dds_mode),
		.burst_mode(burst_mode), .ext_sel(1'b1), .ext_trig(ext_trig), .sw_trig(sw_trig),
		.last_stage(4'h1), .cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_stage(cfg_stage),
		.ctl_in(ctl_in), .sample_addr(sample_addr), .phase_acc(phase_acc),
		.stage_idx(stage_idx), .running(running), .marker(marker), .ctl_out(ctl_out),
		.relay_on(relay_on));
	always #2.5 clk = ~clk;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic wr(input logic [3:0] idx, input stage_s s);
		cfg_we = 1'b1;
		cfg_idx = idx;
		cfg_stage = s;
		cyc(1);
		cfg_we = 1'b0;
		// Idle clock keeps back-to-back writes from toggling the strobe in one step
		cyc(1);
	endtask : wr
	task automatic trig();
		sw_trig = 1'b1;
		cyc(1);
		sw_trig = 1'b0;
	endtask : trig
	task automatic wait_idx(input logic [3:0] v);
		int k;
		k = 0;
		while (stage_idx !== v && k < 40) begin
			cyc(1);
			k++;
		end
		chk("stage index", {28'h0, v}, {28'h0, stage_idx});
	endtask : wait_idx
	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict
	// Marker monitor; gaps of 30 clocks or more are stage changes, not passes
	always @(negedge clk) begin
		cnt++;
		if (marker === 1'b1 && mlen == 0) begin
			nrise++;
			chk("marker start", 32'h8, {18'h0, sample_addr});
			if (nrise > 1 && cnt - lastr < 30) chk("marker period", 32'h10, cnt - lastr);
			lastr = cnt;
		end
		if (marker === 1'b1) begin
			mlen++;
		end else if (mlen != 0) begin
			chk("marker width", 32'h8, mlen);
			mlen = 0;
		end
	end
	initial begin
		#20000;
		miscompares++;
		give_verdict();
	end
	initial begin
		cyc(10);
		chk("reset outputs", 32'h0, {29'h0, relay_on, marker, running});
		arst_n = 1'b1;
		wr(4'h0, '{base: 14'h0, len: 16'h10, loops: 8'h1, mark_en: 1'b1, mark_off: 16'h9,
			freq: 32'h5, dur: 24'h3, default: '0});
		wr(4'h1, '{base: 14'h100, len: 16'h10, loops: 8'h1, mark_en: 1'b1, mark_off: 16'h10,
			freq: 32'h7, dur: 24'h3, default: '0});
		run = 1'b1;
		cyc(2);
		trig();
		cyc(80);
		chk("first stage held", 32'h0, {28'h0, stage_idx});
		$display("Test arb burst start done");
		// Software keeps offset trim off: attenuator sizes are not known here
		ctl_in = 8'h56;
		cyc(1);
		chk("output path", 32'h56, {24'h0, ctl_out});
		chk("relay grounded", 32'h0, {31'h0, relay_on});
		chk("still running", 32'h1, {31'h0, running});
		cyc(40);
		$display("Test output path done");
		trig();
		wait_idx(4'h1);
		cyc(1);
		chk("new stage first sample", 32'h100, {18'h0, sample_addr});
		p = nrise;
		cyc(40);
		chk("no marker out of range", p, nrise);
		trig();
		wait_idx(4'h0);
		$display("Test stage advance done");
		run = 1'b0;
		cyc(2);
		chk("stopped", 32'h0, {30'h0, marker, running});
		$display("Test stop done");
		dds_mode = 1'b1;
		run = 1'b1;
		cyc(2);
		trig();
		cyc(30);
		chk("dds duration ignored", 32'h0, {28'h0, stage_idx});
		p = phase_acc;
		cyc(1);
		chk("dds step", 32'h5, phase_acc - p);
		p = phase_acc;
		src.fire();
		wait_idx(4'h1);
		// Four clocks at the old word, then twelve at the new one
		chk("phase continuous", 32'h68, phase_acc - p);
		cyc(30);
		chk("one ext trigger", 32'h1, {28'h0, stage_idx});
		$display("Test dds burst done");
		run = 1'b0;
		cyc(2);
		burst_mode = 1'b0;
		run = 1'b1;
		cyc(2);
		trig();
		wait_idx(4'h1);
		cyc(2);
		chk("dds duration held", 32'h1, {28'h0, stage_idx});
		cyc(1);
		chk("dds duration done", 32'h0, {28'h0, stage_idx});
		$display("Test dds continuous done");
		give_verdict();
	end
endmodule : wfm_seq_tb
`default_nettype wire
